// file: hw/camera_lane_defines.svh
`ifndef CAMERA_LANE_DEFINES_SVH
`define CAMERA_LANE_DEFINES_SVH

// ----------------------------------------------------------------
// Bus addresses, 8-bit form, write address (bit 0 clear); port address also in 7-bit form
// ----------------------------------------------------------------
`define CAM_SENSOR_ADDR 8'hBA
`define CAM_PORT_ADDR 8'h82
`define CAM_PORT_ADDR7 7'h41

// ----------------------------------------------------------------
// Port device register pointers
// ----------------------------------------------------------------
`define CAM_REG_OUT 8'h00
`define CAM_REG_IN 8'h01
`define CAM_REG_DIR 8'h03

// ----------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------
`define CAM_SHIFT_BIT 0
`define CAM_OUT_RST 4'h0
`define CAM_DIR_RST 3'h7
`define CAM_IN_UNUSED 4'hF
`define CAM_UNUSED_ZERO 4'h0
`define CAM_NARROW_LANES 8
`define CAM_LANE_SHIFT 2
`define CAM_BYTE_BITS 4'h8

`endif

// file: hw/camera_lane_pkg.sv
package camera_lane_pkg;

    // Serial slave states, Gray coded along idle-receive-ack-send-masterack
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RX = 3'h1,
        ST_ACK = 3'h3,
        ST_TX = 3'h2,
        ST_MACK = 3'h6
    } slave_state_e;

    typedef struct packed {
        logic [9:0] lanes;
        logic line_valid;
        logic frame_valid;
        logic strobe;
    } pixel_bus_s;

endpackage

// file: hw/camera_lane_shift_ctrl.sv
// What this block does
// - Sensor answers at 0xBA always; port device at 0x82 only on mux variant.
// - Shifting puts sensor bits 9..2 on lanes 7..0; lanes 9..8 always bits 9..8.
// - Port bit 0 selects lane mode; zero unshifted is default, one shifted.
// - Output register 0x00 holds shift in D0, user lines in D1..D3.
// - Direction register 0x03 holds user line directions in D1..D3; D0 is zero.
// - Lane shifting exists only on the mux variant; others never shift.
// - In snapshot mode a high trigger level starts a capture.
// - A high strobe pulse marks array reset and capture complete.
// - Low sensor reset resets the sensor and its registers to defaults.
// - Sensor reset leaves port device and lane multiplexer settings untouched.
// - High output enable tristates lanes, line, frame, pixel clock and strobe.
// - Output enable is absent on mux variant and default build; always driven.
// - Direction bit one makes a user line input, the default; zero output.

`timescale 1ns/100ps
`default_nettype none
`include "camera_lane_defines.svh"

module camera_lane_shift_ctrl #(
    parameter bit MUX_VARIANT = 1'h1,
    parameter bit OE_FITTED = 1'h0
) (
    // System clock and power-on reset
    input wire logic CLK_SYS_I,
    input wire logic RESETN_I,
    // Configuration bus pins
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_O,
    // Sensor side, pixel clock domain
    input wire logic PIXEL_CLOCK_I,
    input wire logic [9:0] SENSOR_LANES_I,
    input wire logic SENSOR_LINE_VALID_I,
    input wire logic SENSOR_FRAME_VALID_I,
    input wire logic SENSOR_STROBE_I,
    // Host pixel pins
    output logic [9:0] PIXEL_LANES_O,
    output logic [9:0] PIXEL_LANES_OE_O,
    output logic LINE_VALID_O,
    output logic LINE_VALID_OE_O,
    output logic FRAME_VALID_O,
    output logic FRAME_VALID_OE_O,
    output logic PIXEL_CLOCK_OE_O,
    output logic STROBE_O,
    output logic STROBE_OE_O,
    // Host control pins
    input wire logic TRIGGER_PIN_I,
    input wire logic SENSOR_RESET_N_I,
    input wire logic OUTPUT_ENABLE_N_I,
    output logic SENSOR_TRIGGER_O,
    output logic SENSOR_RESET_N_O,
    // User lines
    input wire logic [2:0] USER_LINES_I,
    output logic [2:0] USER_LINES_O,
    output logic [2:0] USER_LINES_OE_O
);

    // ----------------------------------------------------------------
    // Pin synchronisers, system domain
    // ----------------------------------------------------------------
    logic scl_s1_q, scl_s2_q, scl_d3_q;
    logic sda_s1_q, sda_s2_q, sda_d3_q;
    logic trig_s1_q, trig_s2_q;
    logic srst_s1_q, srst_s2_q;
    logic [2:0] user_s1_q, user_s2_q;

    always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            {scl_s1_q, scl_s2_q, scl_d3_q} <= 3'h7;
            {sda_s1_q, sda_s2_q, sda_d3_q} <= 3'h7;
            {trig_s1_q, trig_s2_q} <= 2'h0;
            {srst_s1_q, srst_s2_q} <= 2'h0;
            user_s1_q <= 3'h0;
            user_s2_q <= 3'h0;
        end
        else
        begin
            {scl_s1_q, scl_s2_q, scl_d3_q} <= {SCL_I, scl_s1_q, scl_s2_q};
            {sda_s1_q, sda_s2_q, sda_d3_q} <= {SDA_I, sda_s1_q, sda_s2_q};
            {trig_s1_q, trig_s2_q} <= {TRIGGER_PIN_I, trig_s1_q};
            {srst_s1_q, srst_s2_q} <= {SENSOR_RESET_N_I, srst_s1_q};
            user_s1_q <= USER_LINES_I;
            user_s2_q <= user_s1_q;
        end
    end

    // Trigger and sensor reset reach the sensor as clean levels
    assign SENSOR_TRIGGER_O = trig_s2_q;
    assign SENSOR_RESET_N_O = srst_s2_q;

    wire scl_rise = scl_s2_q & ~scl_d3_q;
    wire scl_fall = ~scl_s2_q & scl_d3_q;
    wire bus_start = scl_s2_q & scl_d3_q & sda_d3_q & ~sda_s2_q;
    wire bus_stop = scl_s2_q & scl_d3_q & ~sda_d3_q & sda_s2_q;

    // ----------------------------------------------------------------
    // Port device registers
    // ----------------------------------------------------------------
    // Only the power-on reset clears these; the sensor reset pin never does
    logic [3:0] out_q;
    logic [2:0] dir_q;
    logic [2:0] user_oe_q;
    logic [7:0] ptr_q;
    logic [7:0] shift_q;
    logic [3:0] bit_cnt_q;
    logic is_addr_q, have_ptr_q, rw_q;
    logic [7:0] tx_q;
    logic sda_oe_q;
    logic sda_low_q;
    camera_lane_pkg::slave_state_e state_q;

    wire byte_done = (state_q == camera_lane_pkg::ST_RX) && scl_fall
        && (bit_cnt_q == `CAM_BYTE_BITS);
    wire addr_hit = MUX_VARIANT && (shift_q[7:1] == `CAM_PORT_ADDR7);
    wire wr_en = byte_done && !is_addr_q && have_ptr_q;
    wire wr_out = wr_en && (ptr_q == `CAM_REG_OUT);
    wire wr_dir = wr_en && (ptr_q == `CAM_REG_DIR);
    // Unused register bits read as one on the input register, zero elsewhere
    wire [7:0] rd_out = {`CAM_UNUSED_ZERO, out_q};
    wire [7:0] rd_in = {`CAM_IN_UNUSED, user_s2_q, out_q[`CAM_SHIFT_BIT]};
    wire [7:0] rd_dir = {`CAM_UNUSED_ZERO, dir_q, 1'h0};
    wire [7:0] rd_data = (ptr_q == `CAM_REG_OUT) ? rd_out :
                         (ptr_q == `CAM_REG_IN) ? rd_in :
                         (ptr_q == `CAM_REG_DIR) ? rd_dir : 8'h00;

    always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            out_q <= `CAM_OUT_RST;
            dir_q <= `CAM_DIR_RST;
            user_oe_q <= 3'h0;
        end
        else
        begin
            if (wr_out)
                out_q <= shift_q[3:0];
            if (wr_dir)
                dir_q <= shift_q[3:1];
            user_oe_q <= ~dir_q;
        end
    end

    assign USER_LINES_O = out_q[3:1];
    assign USER_LINES_OE_O = user_oe_q;

    // ----------------------------------------------------------------
    // Configuration bus slave
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            state_q <= camera_lane_pkg::ST_IDLE;
            shift_q <= 8'h00;
            bit_cnt_q <= 4'h0;
            is_addr_q <= 1'h0;
            have_ptr_q <= 1'h0;
            rw_q <= 1'h0;
            ptr_q <= 8'h00;
            tx_q <= 8'h00;
            sda_oe_q <= 1'h0;
        end
        else if (bus_start)
        begin
            state_q <= camera_lane_pkg::ST_RX;
            bit_cnt_q <= 4'h0;
            is_addr_q <= 1'h1;
            sda_oe_q <= 1'h0;
        end
        else if (bus_stop)
        begin
            state_q <= camera_lane_pkg::ST_IDLE;
            sda_oe_q <= 1'h0;
        end
        else
        begin
            unique case (state_q)
                camera_lane_pkg::ST_IDLE:
                begin
                    sda_oe_q <= 1'h0;
                end
                camera_lane_pkg::ST_RX:
                begin
                    if (scl_rise)
                    begin
                        shift_q <= {shift_q[6:0], sda_s2_q};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end
                    else if (byte_done)
                    begin
                        // Foreign addresses, the sensor's among them, are left unanswered
                        if (is_addr_q && !addr_hit)
                            state_q <= camera_lane_pkg::ST_IDLE;
                        else
                        begin
                            state_q <= camera_lane_pkg::ST_ACK;
                            sda_oe_q <= 1'h1;
                        end
                        if (is_addr_q)
                        begin
                            rw_q <= shift_q[0];
                            have_ptr_q <= 1'h0;
                        end
                        else if (!have_ptr_q)
                        begin
                            ptr_q <= shift_q;
                            have_ptr_q <= 1'h1;
                        end
                    end
                end
                camera_lane_pkg::ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        bit_cnt_q <= 4'h0;
                        is_addr_q <= 1'h0;
                        if (is_addr_q && rw_q)
                        begin
                            state_q <= camera_lane_pkg::ST_TX;
                            tx_q <= rd_data;
                            sda_oe_q <= ~rd_data[7];
                        end
                        else
                        begin
                            state_q <= camera_lane_pkg::ST_RX;
                            sda_oe_q <= 1'h0;
                        end
                    end
                end
                camera_lane_pkg::ST_TX:
                begin
                    if (scl_rise)
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    else if (scl_fall)
                    begin
                        if (bit_cnt_q == `CAM_BYTE_BITS)
                        begin
                            state_q <= camera_lane_pkg::ST_MACK;
                            sda_oe_q <= 1'h0;
                        end
                        else
                        begin
                            tx_q <= {tx_q[6:0], 1'h0};
                            sda_oe_q <= ~tx_q[6];
                        end
                    end
                end
                camera_lane_pkg::ST_MACK:
                begin
                    // A not-acknowledge ends the read; the stop follows
                    if (scl_rise && sda_s2_q)
                        state_q <= camera_lane_pkg::ST_IDLE;
                    else if (scl_fall)
                    begin
                        state_q <= camera_lane_pkg::ST_TX;
                        bit_cnt_q <= 4'h0;
                        tx_q <= rd_data;
                        sda_oe_q <= ~rd_data[7];
                    end
                end
                default:
                begin
                    state_q <= camera_lane_pkg::ST_IDLE;
                    sda_oe_q <= 1'h0;
                end
            endcase
        end
    end

    // Open drain: the data pin only ever pulls low
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
            sda_low_q <= 1'h0;
        else
            sda_low_q <= 1'h0;
    end

    assign SDA_O = sda_low_q;
    assign SDA_OE_O = sda_oe_q;

    // ----------------------------------------------------------------
    // Pixel clock domain: lane multiplexer and pad enables
    // ----------------------------------------------------------------
    logic shift_s1_q, shift_s2_q;
    logic oen_s1_q, oen_s2_q;
    logic pad_oe_q;
    camera_lane_pkg::pixel_bus_s pix_q;
    logic [9:0] lanes_d;

    // The shift setting is a slow level, so two flip-flops carry it safely
    wire shift_req = MUX_VARIANT && out_q[`CAM_SHIFT_BIT];
    wire oe_ctrl = OE_FITTED && !MUX_VARIANT;

    genvar gi;
    generate
        for (gi = 0; gi < 10; gi++)
        begin : g_lane
            if (gi < `CAM_NARROW_LANES)
            begin : g_low
                assign lanes_d[gi] = shift_s2_q ?
                    SENSOR_LANES_I[gi + `CAM_LANE_SHIFT] : SENSOR_LANES_I[gi];
            end
            else
            begin : g_top
                assign lanes_d[gi] = SENSOR_LANES_I[gi];
            end
        end
    endgenerate

    always_ff @(posedge PIXEL_CLOCK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            {shift_s1_q, shift_s2_q} <= 2'h0;
            {oen_s1_q, oen_s2_q} <= 2'h0;
            pad_oe_q <= 1'h0;
            pix_q <= '0;
        end
        else
        begin
            {shift_s1_q, shift_s2_q} <= {shift_req, shift_s1_q};
            {oen_s1_q, oen_s2_q} <= {OUTPUT_ENABLE_N_I, oen_s1_q};
            pad_oe_q <= oe_ctrl ? ~oen_s2_q : 1'h1;
            pix_q.lanes <= lanes_d;
            pix_q.line_valid <= SENSOR_LINE_VALID_I;
            pix_q.frame_valid <= SENSOR_FRAME_VALID_I;
            pix_q.strobe <= SENSOR_STROBE_I;
        end
    end

    // Pads stay disabled until the first pixel clock edge after reset
    assign PIXEL_LANES_O = pix_q.lanes;
    assign LINE_VALID_O = pix_q.line_valid;
    assign FRAME_VALID_O = pix_q.frame_valid;
    assign STROBE_O = pix_q.strobe;
    assign PIXEL_LANES_OE_O = {10{pad_oe_q}};
    assign LINE_VALID_OE_O = pad_oe_q;
    assign FRAME_VALID_OE_O = pad_oe_q;
    assign PIXEL_CLOCK_OE_O = pad_oe_q;
    assign STROBE_OE_O = pad_oe_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    shifted_lanes_a: assert property (
        @(posedge PIXEL_CLOCK_I) disable iff (!RESETN_I)
        shift_s2_q |=> PIXEL_LANES_O[7:0] == $past(SENSOR_LANES_I[9:2]))
        else $error("shifted lanes wrong");

    top_lanes_a: assert property (
        @(posedge PIXEL_CLOCK_I) disable iff (!RESETN_I)
        1'h1 |=> PIXEL_LANES_O[9:8] == $past(SENSOR_LANES_I[9:8]))
        else $error("top lanes wrong");

    unshifted_lanes_a: assert property (
        @(posedge PIXEL_CLOCK_I) disable iff (!RESETN_I)
        !shift_s2_q |=> PIXEL_LANES_O == $past(SENSOR_LANES_I))
        else $error("unshifted lanes wrong");

    no_mux_shift_a: assert property (
        @(posedge PIXEL_CLOCK_I) disable iff (!RESETN_I)
        !MUX_VARIANT |-> !shift_s2_q)
        else $error("shift on plain variant");

    pad_tristate_a: assert property (
        @(posedge PIXEL_CLOCK_I) disable iff (!RESETN_I)
        (oe_ctrl && OUTPUT_ENABLE_N_I) [*3] |=> !STROBE_OE_O && !PIXEL_CLOCK_OE_O)
        else $error("outputs not tristated");

    always_driven_a: assert property (
        @(posedge PIXEL_CLOCK_I) disable iff (!RESETN_I)
        !oe_ctrl |=> PIXEL_LANES_OE_O == 10'h3FF && LINE_VALID_OE_O)
        else $error("outputs not driven");

    strobe_pass_a: assert property (
        @(posedge PIXEL_CLOCK_I) disable iff (!RESETN_I)
        $rose(SENSOR_STROBE_I) |=> STROBE_O)
        else $error("strobe lost");

    trigger_pass_a: assert property (
        @(posedge CLK_SYS_I) disable iff (!RESETN_I)
        TRIGGER_PIN_I [*3] |=> SENSOR_TRIGGER_O)
        else $error("trigger not passed");

    sensor_reset_a: assert property (
        @(posedge CLK_SYS_I) disable iff (!RESETN_I)
        !SENSOR_RESET_N_I [*3] |=> !SENSOR_RESET_N_O)
        else $error("sensor reset not passed");

    shift_persist_a: assert property (
        @(posedge CLK_SYS_I) disable iff (!RESETN_I)
        (!SENSOR_RESET_N_O && !wr_out) |=> $stable(out_q))
        else $error("port setting disturbed");

    out_write_a: assert property (
        @(posedge CLK_SYS_I) disable iff (!RESETN_I)
        wr_out |=> out_q == $past(shift_q[3:0]))
        else $error("output register write lost");

    dir_zero_a: assert property (
        @(posedge CLK_SYS_I) disable iff (!RESETN_I)
        wr_dir |=> !rd_dir[0] && dir_q == $past(shift_q[3:1]))
        else $error("direction register wrong");

    user_dir_a: assert property (
        @(posedge CLK_SYS_I) disable iff (!RESETN_I)
        $changed(dir_q) |=> USER_LINES_OE_O == ~$past(dir_q))
        else $error("user line direction wrong");

    addr_ack_a: assert property (
        @(posedge CLK_SYS_I) disable iff (!RESETN_I)
        (byte_done && is_addr_q && !bus_start && !bus_stop && addr_hit)
        |=> state_q == camera_lane_pkg::ST_ACK && SDA_OE_O)
        else $error("own address not acknowledged");

endmodule

`default_nettype wire

// file: bench/host_bus_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "camera_lane_defines.svh"

module host_bus_model (
    // Clock and pull-down request from the block
    input wire logic clk_i,
    input wire logic sda_oe_i,
    // Bus wires as everyone sees them
    output logic scl_o,
    output logic sda_o
);
    logic sda_hi;

    // ----------------------------------------
    // Open-drain data wire with pull-up
    // ----------------------------------------
    assign sda_o = sda_hi & ~sda_oe_i;

    initial
    begin
        scl_o = 1'b1;
        sda_hi = 1'b1;
    end

    task automatic w(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask

    // Also serves as repeated start: data goes high while the clock is low
    task automatic start();
        sda_hi = 1'b1;
        w(10);
        scl_o = 1'b1;
        w(10);
        sda_hi = 1'b0;
        w(10);
        scl_o = 1'b0;
    endtask

    task automatic stop();
        sda_hi = 1'b0;
        w(10);
        scl_o = 1'b1;
        w(10);
        sda_hi = 1'b1;
        w(10);
    endtask

    // Sample mid-high so the block's 3-clock turn-around has settled
    task automatic bit_xfer(input logic b, output logic seen);
        sda_hi = b;
        w(10);
        scl_o = 1'b1;
        w(5);
        seen = sda_o;
        w(5);
        scl_o = 1'b0;
    endtask

    // Receiving is sending all ones; mack is the ninth bit the host drives
    task automatic byte_xfer(input logic [7:0] tx, input logic mack,
                             output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_xfer(tx[i], rx[i]);
        bit_xfer(mack, ack);
    endtask

    task automatic probe(input logic [7:0] addr, output logic ack);
        logic [7:0] rx;
        start();
        byte_xfer(addr, 1'b1, rx, ack);
        stop();
    endtask

    task automatic reg_write(input logic [7:0] ptr, input logic [7:0] data,
                             output logic [2:0] acks);
        logic [7:0] rx;
        start();
        byte_xfer({`CAM_PORT_ADDR7, 1'b0}, 1'b1, rx, acks[2]);
        byte_xfer(ptr, 1'b1, rx, acks[1]);
        byte_xfer(data, 1'b1, rx, acks[0]);
        stop();
    endtask

    task automatic reg_read(input logic [7:0] ptr, output logic [7:0] data,
                            output logic [2:0] acks);
        logic [7:0] rx;
        logic nack;
        start();
        byte_xfer({`CAM_PORT_ADDR7, 1'b0}, 1'b1, rx, acks[2]);
        byte_xfer(ptr, 1'b1, rx, acks[1]);
        start();
        byte_xfer({`CAM_PORT_ADDR7, 1'b1}, 1'b1, rx, acks[0]);
        byte_xfer(8'hFF, 1'b1, data, nack);
        stop();
    endtask
endmodule

`default_nettype wire

// file: bench/test_camera_lane_shift_ctrl.sv
`timescale 1ns/100ps
`default_nettype none

module test_camera_lane_shift_ctrl;
    logic clk_sys_i, resetn_i, pclk, scl, sda, sda_oe, sda_out;
    logic [9:0] lanes_in, lanes_out, lanes_oe;
    logic lv, fv, st, lv_o, fv_o, st_o, lv_oe, fv_oe, pc_oe, st_oe;
    logic trig, srst_n, oe_n, trig_o, srst_n_o;
    logic [2:0] ul_in, ul_out, ul_oe;
    logic [7:0] rd_q;
    logic [9:0] lanes_p, lanes_oe_p;
    logic st_oe_p;
    int fail_count, checks_done, cycles;

    camera_lane_shift_ctrl i_camera_lane_shift_ctrl (
        .CLK_SYS_I(clk_sys_i), .RESETN_I(resetn_i),
        .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_out), .SDA_OE_O(sda_oe),
        .PIXEL_CLOCK_I(pclk), .SENSOR_LANES_I(lanes_in),
        .SENSOR_LINE_VALID_I(lv), .SENSOR_FRAME_VALID_I(fv), .SENSOR_STROBE_I(st),
        .PIXEL_LANES_O(lanes_out), .PIXEL_LANES_OE_O(lanes_oe),
        .LINE_VALID_O(lv_o), .LINE_VALID_OE_O(lv_oe),
        .FRAME_VALID_O(fv_o), .FRAME_VALID_OE_O(fv_oe),
        .PIXEL_CLOCK_OE_O(pc_oe), .STROBE_O(st_o), .STROBE_OE_O(st_oe),
        .TRIGGER_PIN_I(trig), .SENSOR_RESET_N_I(srst_n), .OUTPUT_ENABLE_N_I(oe_n),
        .SENSOR_TRIGGER_O(trig_o), .SENSOR_RESET_N_O(srst_n_o),
        .USER_LINES_I(ul_in), .USER_LINES_O(ul_out), .USER_LINES_OE_O(ul_oe)
    );

    // Plain variant with the output enable fitted: never shifts, can tristate
    camera_lane_shift_ctrl #(
        .MUX_VARIANT(1'h0),
        .OE_FITTED(1'h1)
    ) i_camera_lane_shift_ctrl_plain (
        .CLK_SYS_I(clk_sys_i), .RESETN_I(resetn_i),
        .SCL_I(scl), .SDA_I(sda), .SDA_O(), .SDA_OE_O(),
        .PIXEL_CLOCK_I(pclk), .SENSOR_LANES_I(lanes_in),
        .SENSOR_LINE_VALID_I(lv), .SENSOR_FRAME_VALID_I(fv), .SENSOR_STROBE_I(st),
        .PIXEL_LANES_O(lanes_p), .PIXEL_LANES_OE_O(lanes_oe_p),
        .LINE_VALID_O(), .LINE_VALID_OE_O(), .FRAME_VALID_O(), .FRAME_VALID_OE_O(),
        .PIXEL_CLOCK_OE_O(), .STROBE_O(), .STROBE_OE_O(st_oe_p),
        .TRIGGER_PIN_I(trig), .SENSOR_RESET_N_I(srst_n), .OUTPUT_ENABLE_N_I(oe_n),
        .SENSOR_TRIGGER_O(), .SENSOR_RESET_N_O(),
        .USER_LINES_I(ul_in), .USER_LINES_O(), .USER_LINES_OE_O()
    );

    host_bus_model i_host_bus_model (
        .clk_i(clk_sys_i), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda)
    );

    // ----------------------------------------
    // Clocks and hang guard
    // ----------------------------------------
    initial
    begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    // Sensor pixel clock runs free, unrelated in phase
    initial
    begin
        pclk = 1'b0;
        #7;
        forever #15 pclk = ~pclk;
    end

    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            fail_count++;
            print_verdict();
        end
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic print_verdict();
        if (fail_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic sclk(input int n);
        repeat (n) @(posedge clk_sys_i);
        #2;
    endtask

    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        logic [2:0] a;
        i_host_bus_model.reg_write(p, d, a);
        check({13'h0, a}, 16'h0000);
    endtask

    task automatic rd(input logic [7:0] p, input logic [7:0] exp);
        logic [2:0] a;
        i_host_bus_model.reg_read(p, rd_q, a);
        check({13'h0, a}, 16'h0000);
        check({8'h0, rd_q}, {8'h0, exp});
    endtask

    // Bits 12:10 carry line valid, frame valid and strobe
    task automatic pix(input logic [12:0] v, input logic [12:0] exp);
        @(posedge pclk);
        #2;
        {lv, fv, st, lanes_in} = v;
        @(posedge pclk);
        #2;
        check({3'h0, lv_o, fv_o, st_o, lanes_out}, {3'h0, exp});
    endtask

    function automatic logic [12:0] shifted(input logic [12:0] v);
        return {v[12:10], v[9:8], v[9:2]};
    endfunction

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset_values();
        check({13'h0, ul_oe}, 16'h0000);
        check({13'h0, ul_out}, 16'h0000);
        check({6'h0, lanes_oe}, 16'h03FF);
        check({12'h0, lv_oe, fv_oe, pc_oe, st_oe}, 16'h000F);
        check({6'h0, lanes_oe_p}, 16'h03FF);
        rd(8'h00, 8'h00);
        rd(8'h03, 8'h0E);
    endtask

    task automatic t_plain();
        pix({3'h6, 10'h2A7}, {3'h6, 10'h2A7});
        pix({3'h5, 10'h15A}, {3'h5, 10'h15A});
    endtask

    // Shift is set between frames with a read-modify-write of the port
    task automatic t_shift();
        logic [2:0] a;
        i_host_bus_model.reg_read(8'h00, rd_q, a);
        wr(8'h00, rd_q | 8'h01);
        repeat (6) @(posedge pclk);
        pix({3'h6, 10'h2A7}, shifted({3'h6, 10'h2A7}));
        pix({3'h1, 10'h103}, shifted({3'h1, 10'h103}));
        check({6'h0, lanes_p}, 16'h0103);
        rd(8'h00, 8'h01);
    endtask

    task automatic t_user_lines();
        wr(8'h03, 8'h00);
        check({13'h0, ul_oe}, 16'h0007);
        wr(8'h00, 8'hFB);
        check({13'h0, ul_out}, 16'h0005);
        rd(8'h00, 8'h0B);
        ul_in = 3'h6;
        rd(8'h01, 8'hFD);
        rd(8'h03, 8'h00);
        wr(8'h03, 8'h0E);
        check({13'h0, ul_oe}, 16'h0000);
    endtask

    task automatic t_sensor_reset();
        srst_n = 1'b0;
        sclk(4);
        check({15'h0, srst_n_o}, 16'h0000);
        srst_n = 1'b1;
        sclk(4);
        check({15'h0, srst_n_o}, 16'h0001);
        rd(8'h00, 8'h0B);
        pix({3'h2, 10'h3C5}, shifted({3'h2, 10'h3C5}));
    endtask

    task automatic t_trigger_oe();
        trig = 1'b1;
        sclk(4);
        check({15'h0, trig_o}, 16'h0001);
        trig = 1'b0;
        sclk(4);
        check({15'h0, trig_o}, 16'h0000);
        oe_n = 1'b1;
        repeat (6) @(posedge pclk);
        #2;
        check({6'h0, lanes_oe}, 16'h03FF);
        check({12'h0, lv_oe, fv_oe, pc_oe, st_oe}, 16'h000F);
        check({5'h0, st_oe_p, lanes_oe_p}, 16'h0000);
        oe_n = 1'b0;
        repeat (6) @(posedge pclk);
        #2;
        check({5'h0, st_oe_p, lanes_oe_p}, 16'h07FF);
    endtask

    // Sensor address belongs to another device; then the port still answers
    task automatic t_foreign();
        logic ack;
        i_host_bus_model.probe(8'hBA, ack);
        check({15'h0, ack}, 16'h0001);
        i_host_bus_model.probe(8'h80, ack);
        check({15'h0, ack}, 16'h0001);
        rd(8'h00, 8'h0B);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        resetn_i = 1'b0;
        lanes_in = 10'h000;
        {lv, fv, st} = 3'h0;
        trig = 1'b0;
        srst_n = 1'b1;
        oe_n = 1'b0;
        ul_in = 3'h0;
        fail_count = 0;
        checks_done = 0;
        cycles = 0;
        sclk(12);
        resetn_i = 1'b1;
        sclk(4);
        t_reset_values();
        t_plain();
        t_shift();
        t_user_lines();
        t_sensor_reset();
        t_trigger_oe();
        t_foreign();
        print_verdict();
    end
endmodule

`default_nettype wire
